// >>> rtl/rti_rule_access.sv
// rti_rule_access: indirect access engine for one port's copy of the ingress rule table
// assumes an APB master on pclk; one instance per switch port
`timescale 1ns/1ps
module rti_rule_access #(
  parameter int ENTRIES = 16,
  parameter int XFER_WAIT = rti_pkg::XFER_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ****************************************
  // register state
  // ****************************************
  logic [7:0] data_reg [rti_pkg::NUM_BYTES];
  logic [7:0] sel_high_reg;
  logic [7:0] sel_low_reg;
  logic [4:0] ctrl_reg;
  logic wr_done_reg;
  logic rd_done_reg;
  logic [3:0] idx_latched_reg;
  logic dir_latched_reg;
  logic [15:0] mask_latched_reg;
  logic [3:0] wait_reg;
  rti_pkg::rti_state_t state_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic pready_reg;

  // ****************************************
  // address decode
  // ****************************************
  // exact match of one aligned register word
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  wire access_w;
  wire setup_w;
  wire wr_access_w;
  wire is_data_w;
  wire is_sel_high_w;
  wire is_sel_low_w;
  wire is_ctrl_w;
  wire mapped_w;
  wire [3:0] data_idx_w;
  assign access_w = psel && penable;
  assign setup_w = psel && !penable;
  assign wr_access_w = access_w && pwrite;
  assign is_data_w = (paddr[7:6] == rti_pkg::OFF_DATA_BASE[7:6]) && (paddr[1:0] == 2'b00);
  assign is_sel_high_w = reg_hit(paddr, rti_pkg::OFF_SEL_HIGH);
  assign is_sel_low_w = reg_hit(paddr, rti_pkg::OFF_SEL_LOW);
  assign is_ctrl_w = reg_hit(paddr, rti_pkg::OFF_CTRL);
  assign mapped_w = is_data_w || is_sel_high_w || is_sel_low_w || is_ctrl_w;
  assign data_idx_w = paddr[5:2];

  // ****************************************
  // transfer control
  // ****************************************
  wire busy_w;
  wire reg_wr_w;
  wire start_w;
  wire start_dir_w;
  wire [15:0] start_mask_w;
  wire wait_over_w;
  wire move_w;
  wire wr_clear_w;
  wire rd_clear_w;
  wire wr_set_w;
  wire rd_set_w;
  // software writes are ignored while a transfer runs
  assign busy_w = state_reg != rti_pkg::RTI_IDLE;
  assign reg_wr_w = wr_access_w && !busy_w;
  assign start_w = reg_wr_w && is_sel_low_w;
  assign start_dir_w = ctrl_reg[rti_pkg::CTRL_DIR_BIT];
  // data byte n follows mask bit 15-n; low half comes from the starting write
  assign start_mask_w = {sel_high_reg, pwdata[7:0]};
  assign wait_over_w = wait_reg <= 4'h1;
  assign move_w = state_reg == rti_pkg::RTI_MOVE;
  assign wr_clear_w = start_w && start_dir_w;
  assign rd_clear_w = start_w && !start_dir_w;
  assign wr_set_w = move_w && dir_latched_reg;
  assign rd_set_w = move_w && !dir_latched_reg;

  // ****************************************
  // read data selection
  // ****************************************
  wire [7:0] ctrl_view_w;
  wire [7:0] rbyte_w;
  wire [31:0] rdata_w;
  assign ctrl_view_w = {1'b0, wr_done_reg, rd_done_reg, ctrl_reg};
  assign rbyte_w = is_data_w ? data_reg[data_idx_w] :
                   is_sel_high_w ? sel_high_reg :
                   is_sel_low_w ? sel_low_reg :
                   is_ctrl_w ? ctrl_view_w : 8'h00;
  assign rdata_w = {24'h00_0000, rbyte_w};

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_high_reg <= rti_pkg::SEL_RESET;
    end else if (reg_wr_w && is_sel_high_w) begin
      sel_high_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_low_reg <= rti_pkg::SEL_RESET;
    end else if (reg_wr_w && is_sel_low_w) begin
      sel_low_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= rti_pkg::CTRL_RESET;
    end else if (reg_wr_w && is_ctrl_w) begin
      ctrl_reg <= pwdata[rti_pkg::CTRL_DIR_BIT:0];
    end
  end

  // ****************************************
  // bus answer
  // ****************************************
  // read data captured in the setup cycle, held through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_w) begin
      prdata_reg <= rdata_w;
    end
  end

  // zero wait states: every access phase ends at its first edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
      pready_reg <= 1'b1;
    end else begin
      pslverr_reg <= setup_w && !mapped_w;
      pready_reg <= 1'b1;
    end
  end
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign pready = pready_reg;

  // ****************************************
  // transfer engine
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= rti_pkg::RTI_IDLE;
      wait_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        rti_pkg::RTI_IDLE: begin
          if (start_w) begin
            wait_reg <= 4'(XFER_WAIT);
            state_reg <= rti_pkg::RTI_WAIT;
          end
        end
        rti_pkg::RTI_WAIT: begin
          wait_reg <= wait_reg - 4'h1;
          if (wait_over_w) begin
            state_reg <= rti_pkg::RTI_MOVE;
          end
        end
        rti_pkg::RTI_MOVE: begin
          state_reg <= rti_pkg::RTI_IDLE;
        end
        default: begin
          state_reg <= rti_pkg::RTI_IDLE;
        end
      endcase
    end
  end

  // entry, direction and selects frozen for the whole transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_latched_reg <= 4'h0;
      dir_latched_reg <= 1'b0;
      mask_latched_reg <= 16'h0000;
    end else if (start_w) begin
      idx_latched_reg <= ctrl_reg[rti_pkg::CTRL_IDX_MSB:0];
      dir_latched_reg <= start_dir_w;
      mask_latched_reg <= start_mask_w;
    end
  end

  // ****************************************
  // completion flags
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_done_reg <= 1'b1;
    end else if (wr_set_w) begin
      wr_done_reg <= 1'b1;
    end else if (wr_clear_w) begin
      wr_done_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_done_reg <= 1'b1;
    end else if (rd_set_w) begin
      rd_done_reg <= 1'b1;
    end else if (rd_clear_w) begin
      rd_done_reg <= 1'b0;
    end
  end

  // ****************************************
  // data bytes and table storage
  // ****************************************
  // one column of the table per data byte; table contents are not reset
  for (genvar b = 0; b < rti_pkg::NUM_BYTES; b++) begin : g_byte
    logic [7:0] entry_mem [ENTRIES];
    wire sel_w;
    wire load_w;
    wire store_w;
    wire sw_wr_w;
    assign sel_w = mask_latched_reg[rti_pkg::NUM_BYTES - 1 - b];
    assign load_w = rd_set_w && sel_w;
    assign store_w = wr_set_w && sel_w;
    assign sw_wr_w = reg_wr_w && is_data_w && (data_idx_w == 4'(b));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        data_reg[b] <= rti_pkg::DATA_RESET;
      end else if (load_w) begin
        data_reg[b] <= entry_mem[idx_latched_reg];
      end else if (sw_wr_w) begin
        data_reg[b] <= pwdata[7:0];
      end
    end
    always_ff @(posedge pclk) begin
      if (store_w) begin
        entry_mem[idx_latched_reg] <= data_reg[b];
      end
    end
  end
endmodule

// >>> rtl/rti_pkg.sv
// rti_pkg: register map, field positions, reset values and timing of the rule table access engine
// assumes a 32-bit APB slave with one register to each aligned word
package rti_pkg;
  // ****************************************
  // register word indices and byte addresses
  // ****************************************
  localparam logic [5:0] IDX_DATA_BASE = 6'h00;
  localparam logic [5:0] IDX_SEL_HIGH = 6'h10;
  localparam logic [5:0] IDX_SEL_LOW = 6'h11;
  localparam logic [5:0] IDX_CTRL = 6'h12;
  localparam logic [7:0] OFF_DATA_BASE = {IDX_DATA_BASE, 2'b00};
  localparam logic [7:0] OFF_SEL_HIGH = {IDX_SEL_HIGH, 2'b00};
  localparam logic [7:0] OFF_SEL_LOW = {IDX_SEL_LOW, 2'b00};
  localparam logic [7:0] OFF_CTRL = {IDX_CTRL, 2'b00};
  // ****************************************
  // access control fields
  // ****************************************
  localparam int CTRL_WR_DONE_BIT = 6;
  localparam int CTRL_RD_DONE_BIT = 5;
  localparam int CTRL_DIR_BIT = 4;
  localparam int CTRL_IDX_MSB = 3;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // ****************************************
  // table access timing, byte count and states
  // ****************************************
  localparam int XFER_TIME_NS = 8;
  localparam int CLK_PERIOD_NS = 4;
  localparam int XFER_CYCLES = (XFER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NUM_BYTES = 16;
  typedef enum logic [1:0] {
    RTI_IDLE = 2'b00,
    RTI_WAIT = 2'b01,
    RTI_MOVE = 2'b11
  } rti_state_t;
endpackage

// >>> testbench/rti_chk_sva.sv
// rti_chk: port assertions for the rule table access engine
// assumes a zero-wait apb slave on pclk, bound to rti_rule_access
`timescale 1ns/1ps
module rti_chk #(
  parameter int XFER_WAIT = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ****
  // transfer tracking
  // ****
  logic [3:0] cnt_reg;
  wire acc = psel && penable;
  wire ctl_rd = acc && !pwrite && paddr == 8'h48;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_reg <= 4'h0;
    else if (acc && pwrite && paddr == 8'h44 && cnt_reg == 4'h0) cnt_reg <= 4'(XFER_WAIT + 1);
    else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err; acc && !pwrite && paddr > 8'h48 |-> pslverr && prdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("unmapped read not refused");
  property p_noerr; acc && paddr <= 8'h48 && paddr[1:0] == 2'b00 |-> !pslverr; endproperty
  a_noerr: assert property (p_noerr) else $error("mapped access refused");
  property p_busy; ctl_rd && $past(cnt_reg) != 4'h0 |-> prdata[6:5] != 2'b11; endproperty
  a_busy: assert property (p_busy) else $error("flag not cleared in transfer");
  property p_idle; ctl_rd && $past(cnt_reg) == 4'h0 |-> prdata[6:5] == 2'b11; endproperty
  a_idle: assert property (p_idle) else $error("flag low while idle");
  property p_rsv; ctl_rd |-> prdata[31:7] == 25'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("ctrl upper bits set");
  property p_sel; acc && !pwrite && paddr inside {8'h40, 8'h44} |-> prdata[31:8] == 24'h0; endproperty
  a_sel: assert property (p_sel) else $error("select upper bits set");
  property p_rst; $rose(presetn) |-> prdata == 32'h0000_0000 && !pslverr; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind rti_rule_access rti_chk #(.XFER_WAIT(XFER_WAIT)) u_rti_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));

// >>> testbench/tb.sv
// tb: directed apb tests of the rule table access engine
// assumes a zero-wait slave; transfer wait set to 2, same as the package default
`timescale 1ns/1ps
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [7:0] exp_b [16];
  logic [7:0] sh_t [3] = '{8'h01, 8'h80, 8'h24};
  logic [7:0] sl_t [3] = '{8'h80, 8'h01, 8'h18};
  int n_fail = 0, total_checks = 0, cyc = 0;
  always #2 pclk = ~pclk;
  rti_rule_access #(.XFER_WAIT(2)) u_rti_rule_access (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  task automatic complete_run;
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] x;
    apb(1'b0, a, 32'h0000_0000, x);
    cmp(nm, e, x);
  endtask
  // start a transfer, check the flag drops, poll until both flags set
  task automatic move(input logic [7:0] ctl, input logic [7:0] sh, input logic [7:0] sl);
    logic [31:0] x;
    wr(8'h40, {24'h0, sh});
    wr(8'h48, {24'h0, ctl});
    wr(8'h44, {24'h0, sl});
    rdc(8'h48, {24'h0, 1'b0, ~ctl[4], ctl[4], ctl[4:0]}, "busy ctrl");
    for (int i = 0; i < 20; i++) begin
      apb(1'b0, 8'h48, 32'h0000_0000, x);
      if (x[6:5] === 2'b11) break;
    end
    cmp("done ctrl", {24'h0, 3'b011, ctl[4:0]}, x);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      complete_run;
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h48, 32'h0000_0060, "reset ctrl");
    rdc(8'h40, 32'h0000_0000, "reset sel_high");
    rdc(8'h44, 32'h0000_0000, "reset sel_low");
    for (int n = 0; n < 16; n++) wr(8'(n * 4), {24'h0, 8'hA0 + 8'(n)});
    move(8'h13, 8'hFF, 8'hFF);
    for (int n = 0; n < 16; n++) wr(8'(n * 4), 32'h0000_0000);
    foreach (exp_b[n]) exp_b[n] = 8'h00;
    for (int k = 0; k < 3; k++) begin
      move(8'h03, sh_t[k], sl_t[k]);
      for (int n = 0; n < 16; n++) begin
        if (n < 8 ? sh_t[k][7 - n] : sl_t[k][15 - n]) exp_b[n] = 8'hA0 + 8'(n);
        rdc(8'(n * 4), {24'h0, exp_b[n]}, "data byte");
      end
    end
    for (int n = 0; n < 16; n++) wr(8'(n * 4), 32'h0000_0000);
    move(8'h13, 8'h80, 8'h00);
    move(8'h1C, 8'hFF, 8'hFF);
    move(8'h03, 8'hFF, 8'hFF);
    for (int n = 0; n < 16; n++) rdc(8'(n * 4), {24'h0, n == 0 ? 8'h00 : 8'hA0 + 8'(n)}, "part write");
    rdc(8'h4C, 32'h0000_0000, "unmapped");
    complete_run;
  end
endmodule
